// File: hw/tcu_pkg.sv
// Package of constants and types for the eight-bit timer counter unit
package tcu_pkg;

    // Register offsets on the plain register port
    localparam logic [2:0] ADDR_CONTROL      = 3'h0;
    localparam logic [2:0] ADDR_COUNT        = 3'h1;
    localparam logic [2:0] ADDR_COMPARE      = 3'h2;
    localparam logic [2:0] ADDR_ASYNC_STATUS = 3'h3;
    localparam logic [2:0] ADDR_FLAG         = 3'h4;
    localparam logic [2:0] ADDR_MASK         = 3'h5;

    // Field positions
    localparam int ASYNC_SEL_BIT = 3;
    localparam int FLAG_OVF_BIT  = 0;
    localparam int FLAG_CMP_BIT  = 1;

    // Reset values
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] COUNT_RESET   = 8'h00;
    localparam logic [7:0] COMPARE_RESET = 8'h00;
    localparam logic [1:0] FLAG_RESET    = 2'h0;
    localparam logic [1:0] MASK_RESET    = 2'h0;

    // Count extremes
    localparam logic [7:0] COUNT_BOTTOM = 8'h00;
    localparam logic [7:0] COUNT_MAX    = 8'hFF;

    // Waveform modes
    localparam logic [1:0] MODE_NORMAL   = 2'h0;
    localparam logic [1:0] MODE_PC_PWM   = 2'h1;
    localparam logic [1:0] MODE_CTC      = 2'h2;
    localparam logic [1:0] MODE_FAST_PWM = 2'h3;

    // Compare output actions
    localparam logic [1:0] COM_OFF    = 2'h0;
    localparam logic [1:0] COM_TOGGLE = 2'h1;
    localparam logic [1:0] COM_CLEAR  = 2'h2;
    localparam logic [1:0] COM_SET    = 2'h3;

    // Prescaler tap masks, indexed by clock select value
    localparam int         PRESCALE_WIDTH = 10;
    localparam logic [9:0] TAP_DIV1    = 10'h000;
    localparam logic [9:0] TAP_DIV8    = 10'h007;
    localparam logic [9:0] TAP_DIV32   = 10'h01F;
    localparam logic [9:0] TAP_DIV64   = 10'h03F;
    localparam logic [9:0] TAP_DIV128  = 10'h07F;
    localparam logic [9:0] TAP_DIV256  = 10'h0FF;
    localparam logic [9:0] TAP_DIV1024 = 10'h3FF;

    // Control register layout
    typedef struct packed {
        logic       force_cmp;
        logic       wave_mode_lo;
        logic [1:0] com_bits;
        logic       wave_mode_hi;
        logic [2:0] clock_select_bits;
    } tcu_ctrl_s;

    // Register port request
    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } tcu_bus_s;

    typedef enum logic {DIR_UP, DIR_DOWN} tcu_dir_e;

endpackage

// File: hw/tcu_timer.sv
// Eight-bit timer counter unit with compare output, overflow and interrupt
//
// How it works
// R1: Count and compare registers are 8 bits.
// R2: Each request has flag and mask bit.
// R3: Timer clock from io clock or crystal.
// R4: Clock select zero stops the counter.
// R5: CPU reads and writes count anytime.
// R6: CPU count write beats counter operations.
// R7: Each tick clears, increments or decrements.
// R8: Bottom at 0x00, max at 0xFF.
// R9: Top is 0xFF or compare value.
// R10: Two wave mode bits choose sequence.
// R11: Overflow flag set per mode, interrupts.
// R12: Compare continuously; match sets flag, drives pin.
// R13: Output either PWM or variable frequency.
// R14: Flag one tick after match; auto clears.
// R15: Count write blocks next tick's match.
// R16: Mode 0 wraps; mode 2 clears on match.
// R17: Crystal input crosses via synchronizer.
`timescale 1ns/1ns
`default_nettype none

module tcu_timer (
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    input  wire logic [2:0] addr,
    input  wire logic [7:0] wr_data,
    input  wire logic       wr_stb,
    input  wire logic       rd_stb,
    output logic      [7:0] rd_data,
    input  wire logic [1:0] irq_ack,
    output logic            irq,
    input  wire logic       crystal_in_pin,
    output logic            crystal_out_pin,
    output logic            compare_output_pin
);

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    // Tap mask for the selected prescale ratio
    function automatic logic [9:0] tap_mask(input logic [2:0] sel);
        unique case (sel)
            3'h2:    tap_mask = tcu_pkg::TAP_DIV8;
            3'h3:    tap_mask = tcu_pkg::TAP_DIV32;
            3'h4:    tap_mask = tcu_pkg::TAP_DIV64;
            3'h5:    tap_mask = tcu_pkg::TAP_DIV128;
            3'h6:    tap_mask = tcu_pkg::TAP_DIV256;
            3'h7:    tap_mask = tcu_pkg::TAP_DIV1024;
            default: tap_mask = tcu_pkg::TAP_DIV1;
        endcase
    endfunction

    // Compare action applied to the output state
    function automatic logic apply_com(input logic [1:0] com, input logic cur);
        unique case (com)
            tcu_pkg::COM_TOGGLE: apply_com = ~cur;
            tcu_pkg::COM_CLEAR:  apply_com = 1'b0;
            tcu_pkg::COM_SET:    apply_com = 1'b1;
            default:             apply_com = cur;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Registers and decode

    tcu_pkg::tcu_bus_s  bus;
    tcu_pkg::tcu_ctrl_s ctrl_q;
    logic [7:0]         count_q;
    logic [7:0]         count_d;
    logic [7:0]         cmp_buf_q;
    logic [7:0]         cmp_act_q;
    logic               async_sel_q;
    logic [1:0]         flag_q;
    logic [1:0]         mask_q;
    tcu_pkg::tcu_dir_e  dir_q;
    tcu_pkg::tcu_dir_e  dir_d;
    logic               block_q;
    logic               oc_q;
    logic [9:0]         pre_q;
    logic [1:0]         xtal_sync_q;
    logic               xtal_prev_q;
    logic [7:0]         rd_data_q;
    logic               irq_q;

    logic [1:0] mode;
    logic       pwm_mode;
    logic       src_en;
    logic       tick;
    logic       wr_count;
    logic       at_bottom;
    logic       at_max;
    logic       at_top;
    logic [7:0] top_value;
    logic       match;
    logic       ovf_evt;
    logic       cmp_evt;
    logic       force_hit;

    assign bus       = '{addr: addr, wdata: wr_data, wr: wr_stb, rd: rd_stb};
    assign mode      = {ctrl_q.wave_mode_hi, ctrl_q.wave_mode_lo}; // R10
    assign pwm_mode  = mode == tcu_pkg::MODE_PC_PWM || mode == tcu_pkg::MODE_FAST_PWM;
    assign wr_count  = bus.wr && bus.addr == tcu_pkg::ADDR_COUNT;
    assign force_hit = bus.wr && bus.addr == tcu_pkg::ADDR_CONTROL && wr_data[7] && !pwm_mode;

    ////////////////////////////////////////////////////////////////////////////
    // Timer clock source

    // Crystal pin is asynchronous: two flops before anything looks at it
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            xtal_sync_q <= 2'h0;
            xtal_prev_q <= 1'b0;
        end else begin
            xtal_sync_q <= {xtal_sync_q[0], crystal_in_pin}; // R17
            xtal_prev_q <= xtal_sync_q[1];
        end
    end

    // Oscillator feedback inverts the sampled level, so it lags by sync delay
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            crystal_out_pin <= 1'b0;
        end else begin
            crystal_out_pin <= ~xtal_sync_q[1];
        end
    end

    // One enable per io clock, or per crystal rising edge when selected
    assign src_en = async_sel_q ? (xtal_sync_q[1] && !xtal_prev_q) : 1'b1; // R3

    // Prescaler free-runs on the source; taps give the slower ticks
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            pre_q <= 10'h000;
        end else if (src_en) begin
            pre_q <= pre_q + 10'h001;
        end
    end

    // No tick at all with clock select zero
    assign tick = src_en && ctrl_q.clock_select_bits != 3'h0 // R4
               && (pre_q & tap_mask(ctrl_q.clock_select_bits))
                  == tap_mask(ctrl_q.clock_select_bits);

    ////////////////////////////////////////////////////////////////////////////
    // Counter unit

    assign at_bottom = count_q == tcu_pkg::COUNT_BOTTOM; // R8
    assign at_max    = count_q == tcu_pkg::COUNT_MAX; // R8
    assign top_value = mode == tcu_pkg::MODE_CTC ? cmp_act_q : tcu_pkg::COUNT_MAX; // R9
    assign at_top    = count_q == top_value;
    assign match     = count_q == cmp_act_q; // R12

    // Next count and direction for the current mode
    always_comb begin
        count_d = count_q;
        dir_d   = dir_q;
        if (wr_count) begin
            count_d = bus.wdata; // R6
        end else if (tick) begin
            unique case (mode)
                tcu_pkg::MODE_PC_PWM: begin
                    if (dir_q == tcu_pkg::DIR_UP && at_max) begin
                        dir_d   = tcu_pkg::DIR_DOWN;
                        count_d = count_q - 8'h01; // R7
                    end else if (dir_q == tcu_pkg::DIR_DOWN && at_bottom) begin
                        dir_d   = tcu_pkg::DIR_UP;
                        count_d = count_q + 8'h01;
                    end else if (dir_q == tcu_pkg::DIR_DOWN) begin
                        count_d = count_q - 8'h01;
                    end else begin
                        count_d = count_q + 8'h01;
                    end
                end
                tcu_pkg::MODE_CTC: begin
                    count_d = at_top ? tcu_pkg::COUNT_BOTTOM : count_q + 8'h01; // R16
                end
                default: begin
                    count_d = count_q + 8'h01; // R16
                    dir_d   = tcu_pkg::DIR_UP;
                end
            endcase
        end
    end

    // Count register, readable and writable with or without ticks
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            count_q <= tcu_pkg::COUNT_RESET; // R1
            dir_q   <= tcu_pkg::DIR_UP;
        end else begin
            count_q <= count_d; // R5
            dir_q   <= dir_d;
        end
    end

    // A count write masks matches until the next tick, even when stopped
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            block_q <= 1'b0;
        end else if (wr_count) begin
            block_q <= 1'b1; // R15
        end else if (tick) begin
            block_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Events

    // Overflow: wrap past MAX, or reaching BOTTOM in phase correct mode
    assign ovf_evt = tick && !wr_count && (mode == tcu_pkg::MODE_PC_PWM // R11
                   ? (dir_q == tcu_pkg::DIR_DOWN && count_q == 8'h01)
                   : at_max);
    // Match seen in the current timer cycle flags on the following tick
    assign cmp_evt = tick && !wr_count && match && !block_q; // R14

    ////////////////////////////////////////////////////////////////////////////
    // Compare buffer

    // PWM modes load the active compare at TOP to avoid odd pulses
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            cmp_buf_q <= tcu_pkg::COMPARE_RESET; // R1
            cmp_act_q <= tcu_pkg::COMPARE_RESET;
        end else begin
            if (bus.wr && bus.addr == tcu_pkg::ADDR_COMPARE) begin
                cmp_buf_q <= bus.wdata;
            end
            if (!pwm_mode && bus.wr && bus.addr == tcu_pkg::ADDR_COMPARE) begin
                cmp_act_q <= bus.wdata;
            end else if (pwm_mode && tick && at_top) begin
                cmp_act_q <= cmp_buf_q; // R12
            end else if (!pwm_mode) begin
                cmp_act_q <= cmp_buf_q;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Waveform generator

    // Non-PWM: set/clear/toggle on match; PWM: pulse width by compare
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            oc_q <= 1'b0;
        end else if (force_hit) begin
            oc_q <= apply_com(ctrl_q.com_bits, oc_q); // Force sets no flag
        end else if (tick && ctrl_q.com_bits != tcu_pkg::COM_OFF) begin
            unique case (mode)
                tcu_pkg::MODE_FAST_PWM: begin
                    if (match && !block_q) begin
                        oc_q <= ctrl_q.com_bits == tcu_pkg::COM_SET; // R13
                    end else if (at_max) begin
                        oc_q <= ctrl_q.com_bits != tcu_pkg::COM_SET;
                    end
                end
                tcu_pkg::MODE_PC_PWM: begin
                    if (match && !block_q) begin
                        oc_q <= (ctrl_q.com_bits == tcu_pkg::COM_SET)
                              ^ (dir_q == tcu_pkg::DIR_DOWN); // R13
                    end
                end
                default: begin
                    if (match && !block_q && !wr_count) begin
                        oc_q <= apply_com(ctrl_q.com_bits, oc_q); // R12
                    end
                end
            endcase
        end
    end

    // Pin follows the internal output state only while an action is chosen
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            compare_output_pin <= 1'b0;
        end else begin
            compare_output_pin <= ctrl_q.com_bits != tcu_pkg::COM_OFF && oc_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control and async select

    // Force bit is a strobe: never stored
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            ctrl_q      <= tcu_pkg::tcu_ctrl_s'(tcu_pkg::CONTROL_RESET);
            async_sel_q <= 1'b0;
        end else begin
            if (bus.wr && bus.addr == tcu_pkg::ADDR_CONTROL) begin
                ctrl_q           <= tcu_pkg::tcu_ctrl_s'(bus.wdata); // R10
                ctrl_q.force_cmp <= 1'b0;
            end
            if (bus.wr && bus.addr == tcu_pkg::ADDR_ASYNC_STATUS) begin
                async_sel_q <= bus.wdata[tcu_pkg::ASYNC_SEL_BIT]; // R3
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Flags, mask and interrupt

    // Set wins over a write-one clear or an acknowledge in the same cycle
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            flag_q <= tcu_pkg::FLAG_RESET;
        end else begin
            flag_q <= (flag_q
                       & ~(bus.wr && bus.addr == tcu_pkg::ADDR_FLAG ? bus.wdata[1:0] : 2'h0)
                       & ~irq_ack) // R14
                    | {cmp_evt, ovf_evt}; // R2
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            mask_q <= tcu_pkg::MASK_RESET;
        end else if (bus.wr && bus.addr == tcu_pkg::ADDR_MASK) begin
            mask_q <= bus.wdata[1:0]; // R2
        end
    end

    // Level interrupt, one cycle behind the flags
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(flag_q & mask_q); // R11
        end
    end
    assign irq = irq_q;

    ////////////////////////////////////////////////////////////////////////////
    // Read port

    // Compare reads show the buffer; unmapped offsets read zero
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            rd_data_q <= 8'h00;
        end else if (bus.rd) begin
            unique case (bus.addr)
                tcu_pkg::ADDR_CONTROL:      rd_data_q <= {1'b0, ctrl_q[6:0]};
                tcu_pkg::ADDR_COUNT:        rd_data_q <= count_q; // R5
                tcu_pkg::ADDR_COMPARE:      rd_data_q <= cmp_buf_q;
                tcu_pkg::ADDR_ASYNC_STATUS: rd_data_q <= {4'h0, async_sel_q, 3'h0};
                tcu_pkg::ADDR_FLAG:         rd_data_q <= {6'h00, flag_q};
                tcu_pkg::ADDR_MASK:         rd_data_q <= {6'h00, mask_q};
                default:                    rd_data_q <= 8'h00;
            endcase
        end else begin
            rd_data_q <= 8'h00;
        end
    end
    assign rd_data = rd_data_q;

endmodule // tcu_timer

`default_nettype wire

// File: verification/tcu_timer_props.sv
// Concurrent checks on the ports of the timer counter unit
`timescale 1ns/1ns
`default_nettype none

module tcu_timer_props (
    input wire logic       sys_clk,
    input wire logic       rst_n,
    input wire logic [2:0] addr,
    input wire logic [7:0] wr_data,
    input wire logic       wr_stb,
    input wire logic       rd_stb,
    input wire logic [7:0] rd_data,
    input wire logic [1:0] irq_ack,
    input wire logic       irq,
    input wire logic       crystal_in_pin,
    input wire logic       crystal_out_pin,
    input wire logic       compare_output_pin
);
    logic [7:0] ctl_q;
    logic [1:0] msk_q;
    logic       as_q;

    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    ////////////////////////////////////////
    // Shadow copies of control, mask and async select, since the checker cannot look inside
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            ctl_q <= 8'h00;
            msk_q <= 2'h0;
            as_q  <= 1'b0;
        end else if (wr_stb && addr == tcu_pkg::ADDR_CONTROL) begin
            ctl_q <= wr_data;
        end else if (wr_stb && addr == tcu_pkg::ADDR_MASK) begin
            msk_q <= wr_data[1:0];
        end else if (wr_stb && addr == tcu_pkg::ADDR_ASYNC_STATUS) begin
            as_q <= wr_data[tcu_pkg::ASYNC_SEL_BIT]; // Crystal ticks are slow
        end
    end

    ////////////////////////////////////////
    AST_RD_IDLE: assert property (!$past(rd_stb) |-> rd_data == 8'h00)
        else $error("read data not zero outside a read");
    AST_RD_UNMAPPED: assert property (rd_stb && addr > 3'h5 |=> rd_data == 8'h00)
        else $error("unmapped read not zero");
    AST_WR_WINS: assert property (wr_stb && addr == tcu_pkg::ADDR_COUNT ##1
        rd_stb && addr == tcu_pkg::ADDR_COUNT |=> rd_data == $past(wr_data, 2))
        else $error("count write lost against a tick");
    AST_STOPPED: assert property (rd_stb && addr == tcu_pkg::ADDR_COUNT &&
        ctl_q[2:0] == 3'h0 ##1 rd_stb && addr == tcu_pkg::ADDR_COUNT
        |=> rd_data == $past(rd_data))
        else $error("stopped counter moved");
    AST_STEP: assert property (rd_stb && addr == tcu_pkg::ADDR_COUNT &&
        ctl_q == 8'h01 && !as_q ##1 rd_stb && addr == tcu_pkg::ADDR_COUNT
        |=> rd_data == $past(rd_data) + 8'h01)
        else $error("count did not step by one");
    AST_IRQ_MASK: assert property (irq |-> $past(msk_q) != 2'h0)
        else $error("interrupt while all masked");
    AST_XTAL: assert property ((rst_n && $stable(crystal_in_pin)) [*4]
        |-> crystal_out_pin != crystal_in_pin)
        else $error("crystal output not inverse of input");
    AST_CMP_OFF: assert property (ctl_q[5:4] == 2'h0 && $past(ctl_q[5:4]) == 2'h0
        |-> !compare_output_pin)
        else $error("compare pin driven with output off");
    AST_OVF_IRQ: assert property (wr_stb && addr == tcu_pkg::ADDR_COUNT && wr_data == 8'hFF
        && ctl_q == 8'h01 && !as_q && msk_q[0] |-> ##[1:4] irq)
        else $error("overflow gave no interrupt");
endmodule // tcu_timer_props

bind tcu_timer tcu_timer_props i_tcu_timer_props (
    .sys_clk(sys_clk), .rst_n(rst_n), .addr(addr), .wr_data(wr_data), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rd_data(rd_data), .irq_ack(irq_ack), .irq(irq),
    .crystal_in_pin(crystal_in_pin), .crystal_out_pin(crystal_out_pin),
    .compare_output_pin(compare_output_pin));
`default_nettype wire

// File: verification/tcu_cpu_model.sv
// CPU side register master for the timer counter unit
`timescale 1ns/1ns
`default_nettype none

module tcu_cpu_model (
    input  wire logic       sys_clk,
    output logic      [2:0] addr,
    output logic      [7:0] wr_data,
    output logic            wr_stb,
    output logic            rd_stb,
    input  wire logic [7:0] rd_data
);
    // Idle bus at time zero
    initial begin
        addr = 3'h0;
        wr_data = 8'h00;
        wr_stb = 1'b0;
        rd_stb = 1'b0;
    end

    ////////////////////////////////////////
    // One access, entered at a rising edge; idle lines get inverted so stale values never help
    task automatic acc(input logic w, input logic [2:0] a, input logic [7:0] d,
                       output logic [7:0] q);
        addr <= a;
        wr_data <= d;
        wr_stb <= w;
        rd_stb <= !w;
        @(posedge sys_clk);
        wr_stb <= 1'b0;
        rd_stb <= 1'b0;
        addr <= ~a;
        wr_data <= ~d;
        #1 q = rd_data;
        @(posedge sys_clk);
    endtask

    // First access, then a read of the same place with no gap
    task automatic pair(input logic w, input logic [2:0] a, input logic [7:0] d,
                        output logic [7:0] q1, output logic [7:0] q2);
        addr <= a;
        wr_data <= d;
        wr_stb <= w;
        rd_stb <= !w;
        @(posedge sys_clk);
        wr_stb <= 1'b0;
        rd_stb <= 1'b1;
        #1 q1 = rd_data;
        @(posedge sys_clk);
        rd_stb <= 1'b0;
        addr <= ~a;
        #1 q2 = rd_data;
        @(posedge sys_clk);
    endtask
endmodule // tcu_cpu_model
`default_nettype wire

// File: verification/test_tcu_timer.sv
// Self-checking testbench of the timer counter unit
`timescale 1ns/1ns
`default_nettype none

module test_tcu_timer;
    localparam logic [2:0] A_CTL = tcu_pkg::ADDR_CONTROL;
    localparam logic [2:0] A_CNT = tcu_pkg::ADDR_COUNT;
    localparam logic [2:0] A_CMP = tcu_pkg::ADDR_COMPARE;
    localparam logic [2:0] A_FLG = tcu_pkg::ADDR_FLAG;
    localparam logic [2:0] A_MSK = tcu_pkg::ADDR_MASK;
    logic       sys_clk;
    logic       rst_n;
    logic [2:0] addr;
    logic [7:0] wr_data;
    logic       wr_stb;
    logic       rd_stb;
    logic [7:0] rd_data;
    logic [1:0] irq_ack;
    logic       irq;
    logic       crystal_in_pin;
    logic       crystal_out_pin;
    logic       compare_output_pin;
    logic [7:0] q;
    logic [7:0] q2;
    logic       pin0;
    int         err_total;
    int         total_checks;

    tcu_timer i_tcu_timer (.sys_clk(sys_clk), .rst_n(rst_n), .addr(addr), .wr_data(wr_data),
        .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data), .irq_ack(irq_ack), .irq(irq),
        .crystal_in_pin(crystal_in_pin), .crystal_out_pin(crystal_out_pin),
        .compare_output_pin(compare_output_pin));
    tcu_cpu_model i_tcu_cpu_model (.sys_clk(sys_clk), .addr(addr), .wr_data(wr_data),
        .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data));

    ////////////////////////////////////////
    // 20 MHz clock, and a slow free-running watch crystal
    always #25 sys_clk = ~sys_clk;
    always begin
        repeat (7) @(posedge sys_clk);
        crystal_in_pin <= ~crystal_in_pin;
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        i_tcu_cpu_model.acc(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [2:0] a, input logic [7:0] e);
        i_tcu_cpu_model.acc(1'b0, a, 8'h00, q);
        chk(q, e);
    endtask

    // Bounded wait; a hang ends the run at once
    task automatic wait_irq(input logic lvl);
        int n;
        n = 0;
        while (irq !== lvl && n < 20) begin
            @(posedge sys_clk);
            n++;
        end
        chk({7'h00, irq}, {7'h00, lvl});
        if (irq !== lvl) results();
    endtask

    task automatic results;
        $display("checks %0d, mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    ////////////////////////////////////////
    initial begin
        sys_clk = 1'b0;
        rst_n = 1'b0;
        irq_ack = 2'h0;
        crystal_in_pin = 1'b0;
        err_total = 0;
        total_checks = 0;
        repeat (6) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        for (int a = 0; a < 8; a++) rd(3'(a), 8'h00);
        // Full eight-bit values held while stopped
        wr(A_CMP, 8'hA5);
        rd(A_CMP, 8'hA5);
        wr(A_CNT, 8'h5A);
        repeat (10) @(posedge sys_clk);
        rd(A_CNT, 8'h5A);
        i_tcu_cpu_model.pair(1'b0, A_CNT, 8'h00, q, q2);
        chk(q2, q);
        // Running at full rate: the write beats the tick, then one step per tick
        wr(A_CTL, 8'h01);
        i_tcu_cpu_model.pair(1'b1, A_CNT, 8'h40, q, q2);
        chk(q, 8'h00);
        chk(q2, 8'h40);
        i_tcu_cpu_model.pair(1'b0, A_CNT, 8'h00, q, q2);
        chk(q2 - q, 8'h01);
        // Wrap past the maximum raises overflow and the interrupt
        wr(A_MSK, 8'h01);
        wr(A_CNT, 8'hFF);
        wait_irq(1'b1);
        wr(A_CTL, 8'h00);
        rd(A_FLG, 8'h01);
        wr(A_FLG, 8'h01);
        rd(A_FLG, 8'h00);
        wait_irq(1'b0);
        // A count write hides the match on the next tick
        wr(A_CMP, 8'h10);
        wr(A_CNT, 8'h10);
        wr(A_CTL, 8'h01);
        repeat (3) @(posedge sys_clk);
        wr(A_CTL, 8'h00);
        rd(A_FLG, 8'h00);
        wr(A_CNT, 8'h0E);
        wr(A_CTL, 8'h01);
        repeat (4) @(posedge sys_clk);
        wr(A_CTL, 8'h00);
        rd(A_FLG, 8'h02);
        chk({7'h00, irq}, 8'h00);
        wr(A_MSK, 8'h02);
        wait_irq(1'b1);
        irq_ack <= 2'h2;
        @(posedge sys_clk);
        irq_ack <= 2'h0;
        wait_irq(1'b0);
        rd(A_FLG, 8'h00);
        // Clear on match keeps the count at or below the compare value
        wr(A_CMP, 8'h05);
        wr(A_CNT, 8'h00);
        wr(A_CTL, 8'h09);
        repeat (40) @(posedge sys_clk);
        for (int i = 0; i < 4; i++) begin
            i_tcu_cpu_model.acc(1'b0, A_CNT, 8'h00, q);
            chk({7'h00, q <= 8'h05}, 8'h01);
        end
        // Up-down mode moves by one either way
        wr(A_CTL, 8'h41);
        repeat (30) @(posedge sys_clk);
        i_tcu_cpu_model.pair(1'b0, A_CNT, 8'h00, q, q2);
        chk({7'h00, (q2 - q == 8'h01) || (q - q2 == 8'h01)}, 8'h01);
        // Forced match toggles the pin while stopped
        wr(A_CTL, 8'h10);
        @(negedge sys_clk);
        pin0 = compare_output_pin;
        @(posedge sys_clk);
        wr(A_CTL, 8'h90);
        repeat (2) @(posedge sys_clk);
        @(negedge sys_clk);
        chk({7'h00, compare_output_pin}, {7'h00, ~pin0});
        @(posedge sys_clk);
        // Fast PWM, clear on match: low after the match, high again after MAX
        wr(A_CMP, 8'h80);
        wr(A_CNT, 8'h70);
        wr(A_CTL, 8'h69);
        repeat (40) @(posedge sys_clk);
        @(negedge sys_clk);
        chk({7'h00, compare_output_pin}, 8'h00);
        repeat (128) @(posedge sys_clk);
        @(negedge sys_clk);
        chk({7'h00, compare_output_pin}, 8'h01);
        @(posedge sys_clk);
        // Crystal clocking runs far slower than the system clock
        wr(A_CTL, 8'h00);
        wr(tcu_pkg::ADDR_ASYNC_STATUS, 8'h08);
        rd(tcu_pkg::ADDR_ASYNC_STATUS, 8'h08);
        wr(A_CNT, 8'h00);
        wr(A_CTL, 8'h01);
        repeat (56) @(posedge sys_clk);
        wr(A_CTL, 8'h00);
        i_tcu_cpu_model.acc(1'b0, A_CNT, 8'h00, q);
        chk({7'h00, q >= 8'h02 && q <= 8'h06}, 8'h01);
        // Second reset in mid-run
        wr(A_CTL, 8'h01);
        rst_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        for (int a = 0; a < 8; a++) rd(3'(a), 8'h00);
        results();
    end
endmodule // test_tcu_timer
`default_nettype wire
